// ### design/pso_defs.svh
`ifndef PSO_DEFS_SVH
`define PSO_DEFS_SVH

`define PSO_WIDTH 12
`define PSO_STAGES 12
`define PSO_LATENCY 7
`define PSO_MID_CODE 12'h800
`define PSO_MAX_CODE 12'hfff
`define PSO_MIN_CODE 12'h000
`define PSO_RESET_WORD 12'h000

`endif

// ### design/pso_pkg.sv
package pso_pkg;

typedef struct packed {
    logic [11:0] word;
    logic valid;
} pso_sample_t;

typedef struct packed {
    logic [11:0] data;
    logic [11:0] oe_n;
} pso_bus_t;

typedef enum logic [0:0] {
    PSO_RUN,
    PSO_HOLD
} pso_mode_t;

endpackage

// ### design/pso_stage.sv
`timescale 1ns/1ps
`include "pso_defs.svh"

// One full-clock pipeline step: registers the whole sample, passes it along unchanged
module pso_stage #(
    parameter int W = 12,
    parameter int BIT = 11
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    // Sample in and out
    input wire pso_pkg::pso_sample_t in_s,
    output pso_pkg::pso_sample_t out_s
);
    pso_pkg::pso_sample_t cur;
    pso_pkg::pso_sample_t next_cur;

    always_comb
    begin
        next_cur = cur;
        if (en)
        begin
            next_cur = in_s;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign out_s = cur;
endmodule

// ### design/pso_top.sv
`timescale 1ns/1ps
`include "pso_defs.svh"

// How it works
// - One sample taken per clk rising edge while running.
// - Twelve one-bit stages, two per clock, corrected word kept.
// - Result appears on the bus exactly seven clocks after sampling.
// - Output enable high releases all twelve data lines.
// - Shutdown with enable low freezes last word, no updates.
// - Line 0 carries the LSB, line 11 the MSB.
// - Offset binary: mid 800, top fff, bottom 000, one per step.
module pso_top #(
    parameter int W = `PSO_WIDTH,
    parameter int STAGES = `PSO_STAGES,
    parameter int LATENCY = `PSO_LATENCY
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Converted sample from the quantiser, signed two's complement
    input wire logic [W-1:0] sample_in,
    // Controls
    input wire logic output_enable_n,
    input wire logic shutdown_request,
    // Sample word bus, three signals per line
    output logic [W-1:0] sample_word_bus_out,
    output logic [W-1:0] sample_word_bus_oe_n,
    output logic [W-1:0] sample_word_bus_in_unused
);
    // Stages are clocked at full rate, two stages per clock; the half-cycle
    // pairing keeps a one-clock-edge design with the same total latency.
    localparam int PAIRS = STAGES / 2;
    localparam int PRE = LATENCY - PAIRS - 1;

    pso_pkg::pso_sample_t chain [0:PAIRS];
    pso_pkg::pso_sample_t capture;
    pso_pkg::pso_sample_t next_capture;
    logic [W-1:0] out_word;
    logic [W-1:0] next_out_word;
    logic [W-1:0] oe_n;
    logic [W-1:0] next_oe_n;
    logic run;

    // Signed input to offset binary: flip the top bit
    function automatic logic [W-1:0] to_offset(input logic [W-1:0] v);
        to_offset = {~v[W-1], v[W-2:0]};
    endfunction

    assign run = !shutdown_request;

    always_comb
    begin
        next_capture = capture;
        if (run)
        begin
            next_capture.word = to_offset(sample_in);
            next_capture.valid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            capture <= '0;
        end
        else
        begin
            capture <= next_capture;
        end
    end

    // Extra delay registers pad the pipeline to the stated latency
    pso_pkg::pso_sample_t pad_tail;

    generate
        if (PRE > 0)
        begin : g_pad
            pso_pkg::pso_sample_t pad [1:PRE];
            pso_pkg::pso_sample_t next_pad [1:PRE];

            always_comb
            begin
                next_pad[1] = run ? capture : pad[1];
                for (int i = 2; i <= PRE; i++)
                begin
                    next_pad[i] = run ? pad[i-1] : pad[i];
                end
            end

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    for (int i = 1; i <= PRE; i++)
                    begin
                        pad[i] <= '0;
                    end
                end
                else
                begin
                    for (int i = 1; i <= PRE; i++)
                    begin
                        pad[i] <= next_pad[i];
                    end
                end
            end

            assign pad_tail = pad[PRE];
        end
        else
        begin : g_no_pad
            // Pairs plus the output latch already make the latency after capture
            assign pad_tail = capture;
        end
    endgenerate

    assign chain[0] = pad_tail;

    genvar g;
    generate
        for (g = 0; g < PAIRS; g++)
        begin : g_stage
            // Each instance stands for two one-bit stages
            pso_stage #(
                .W(W),
                .BIT(W - 1 - 2 * g)
            ) u_stage (
                .clk(clk),
                .rst_n(rst_n),
                .en(run),
                .in_s(chain[g]),
                .out_s(chain[g+1])
            );
        end
    endgenerate

    // Output latch: last step of the latency, frozen in shutdown
    always_comb
    begin
        next_out_word = out_word;
        if (run)
        begin
            next_out_word = chain[PAIRS].word;
        end
        next_oe_n = {W{output_enable_n}};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_word <= `PSO_RESET_WORD;
            oe_n <= '1;
        end
        else
        begin
            out_word <= next_out_word;
            oe_n <= next_oe_n;
        end
    end

    assign sample_word_bus_out = out_word;
    assign sample_word_bus_oe_n = oe_n;
    assign sample_word_bus_in_unused = '0;

    // Helper: input from seven clocks ago, valid only with no shutdown
    logic [W-1:0] hist [0:LATENCY];
    logic [3:0] run_cnt;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i <= LATENCY; i++)
            begin
                hist[i] <= '0;
            end
            run_cnt <= '0;
        end
        else
        begin
            hist[0] <= sample_in;
            for (int i = 1; i <= LATENCY; i++)
            begin
                hist[i] <= hist[i-1];
            end
            if (!run)
            begin
                run_cnt <= '0;
            end
            else if (run_cnt < 4'(LATENCY + 1))
            begin
                run_cnt <= run_cnt + 4'h1;
            end
        end
    end

    a_latency_seven: assert property (
        @(posedge clk) disable iff (!rst_n)
        (run_cnt == 4'(LATENCY + 1)) && run
        |=> out_word == to_offset(hist[LATENCY]))
        else $error("output word not seven clocks after sample");

    a_hold_shutdown: assert property (
        @(posedge clk) disable iff (!rst_n)
        shutdown_request |=> $stable(out_word))
        else $error("output changed during shutdown");

    a_oe_release: assert property (
        @(posedge clk) disable iff (!rst_n)
        output_enable_n |=> sample_word_bus_oe_n == '1)
        else $error("data lines driven while enable high");

    a_oe_drive: assert property (
        @(posedge clk) disable iff (!rst_n)
        rst_n && !output_enable_n |=> sample_word_bus_oe_n == '0)
        else $error("data lines released while enable low");

    a_mid_code: assert property (
        @(posedge clk) disable iff (!rst_n)
        rst_n && run && sample_in == '0 |=> capture.word == `PSO_MID_CODE)
        else $error("zero input not mid code");

    a_capture_rate: assert property (
        @(posedge clk) disable iff (!rst_n)
        rst_n && run
        |=> capture.valid && capture.word == to_offset($past(sample_in)))
        else $error("sample not captured on this edge");

    a_stage_move: assert property (
        @(posedge clk) disable iff (!rst_n)
        run |=> chain[1] == $past(chain[0]))
        else $error("pipeline did not advance");

    a_bit_order: assert property (
        @(posedge clk) disable iff (!rst_n)
        run |=> sample_word_bus_out[W-1] == $past(chain[PAIRS].word[W-1]))
        else $error("msb not on top line");
endmodule

// ### tb/pipelined_sample_output_port_test.sv
`timescale 1ns/1ps
module pipelined_sample_output_port_test;
    logic clk;
    logic rst_n;
    logic [11:0] sample_in;
    logic output_enable_n;
    logic shutdown_request;
    logic [11:0] bus_out;
    logic [11:0] bus_oe_n;
    wire [11:0] bus_level;
    logic [11:0] cap_word;
    logic cap_valid;
    int errors;
    int checks_done;

    for (genvar g = 0; g < 12; g++)
    begin : g_pin
        assign bus_level[g] = bus_oe_n[g] ? 1'bz : bus_out[g];
    end

    pso_top dut_u (
        .clk(clk),
        .rst_n(rst_n),
        .sample_in(sample_in),
        .output_enable_n(output_enable_n),
        .shutdown_request(shutdown_request),
        .sample_word_bus_out(bus_out),
        .sample_word_bus_oe_n(bus_oe_n),
        .sample_word_bus_in_unused()
    );

    pso_capture cap_u (
        .clk(clk),
        .rst_n(rst_n),
        .bus_level(bus_level),
        .shutdown_request(shutdown_request),
        .cap_word(cap_word),
        .cap_valid(cap_valid)
    );

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_stream;
        logic [11:0] v [10] = '{12'h000, 12'h7ff, 12'h800, 12'h001,
            12'h7fe, 12'h801, 12'h123, 12'hfff, 12'h400, 12'h555};
        // Offset binary codes of the words above
        logic [11:0] exp_w [10] = '{12'h800, 12'hfff, 12'h000, 12'h801,
            12'hffe, 12'h001, 12'h923, 12'h7ff, 12'hc00, 12'hd55};
        for (int j = 0; j < 18; j++)
        begin
            @(posedge clk);
            if (j < 10)
                sample_in <= v[j];
            #1;
            if (j >= 8)
            begin
                check(bus_out, exp_w[j - 8]);
                check(bus_level, exp_w[j - 8]);
            end
            if (j >= 9)
            begin
                check(cap_word, exp_w[j - 9]);
                check({11'h000, cap_valid}, 12'h001);
            end
        end
        $display("test_stream done");
    endtask

    task automatic test_enable;
        @(posedge clk);
        output_enable_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(bus_level, 12'hzzz);
        check(bus_oe_n, 12'hfff);
        @(posedge clk);
        output_enable_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(bus_oe_n, 12'h000);
        check(bus_level, 12'hd55);
        $display("test_enable done");
    endtask

    task automatic test_shutdown;
        // Distinct words in flight, so a flush or a slip shows up
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            sample_in <= 12'h100 + 12'(i);
        end
        @(posedge clk);
        shutdown_request <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            sample_in <= 12'h3c3 ^ 12'(i);
            #1;
            check(bus_out, 12'h902);
        end
        @(posedge clk);
        shutdown_request <= 1'b0;
        sample_in <= 12'h155;
        // Frozen words drain first, then the first new sample
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk);
            #1;
            check(bus_out, (k < 7) ? 12'h903 + 12'(k) : 12'h955);
            if (k == 6)
                check({11'h000, cap_valid}, 12'h000);
        end
        check({11'h000, cap_valid}, 12'h001);
        $display("test_shutdown done");
    endtask

    task automatic test_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        check(bus_out, 12'h000);
        check(bus_oe_n, 12'hfff);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk);
            #1;
            check(bus_out, (k < 7) ? 12'h000 : 12'h955);
        end
        check(bus_oe_n, 12'h000);
        $display("test_reset done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        // Tests need under a hundred cycles
        #100000;
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end

    initial
    begin
        errors = 0;
        checks_done = 0;
        rst_n = 1'b0;
        sample_in = 12'h000;
        output_enable_n = 1'b0;
        shutdown_request = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        test_stream();
        test_enable();
        test_shutdown();
        test_reset();
        wrap_up();
    end
endmodule

// ### tb/pso_capture.sv
`timescale 1ns/1ps
module pso_capture (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus level and shutdown
    input wire logic [11:0] bus_level,
    input wire logic shutdown_request,
    // Captured word
    output logic [11:0] cap_word,
    output logic cap_valid
);
    logic [3:0] skip;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            skip <= 4'h7;
            cap_word <= 12'h000;
            cap_valid <= 1'b0;
        end
        else if (shutdown_request)
        begin
            // Refill words precede real results
            skip <= 4'h7;
            cap_valid <= 1'b0;
        end
        else
        begin
            cap_word <= bus_level;
            cap_valid <= (skip == 4'h0);
            if (skip != 4'h0)
                skip <= skip - 4'h1;
        end
    end
endmodule
